// ==== hw/nsa_evt_counter.sv ====
// Purpose: Wrapping event counter with sticky overflow flag
// Assumes: inc_i is a one-cycle pulse on clk_i
// Notes:   An event in the clearing cycle is counted, not lost
`timescale 1ns/10ps
module nsa_evt_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // Control
  input  wire logic         inc_i,
  input  wire logic         clr_i,
  // Status
  output logic      [W-1:0] count_o,
  output logic              ovf_o
);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_o <= '0;
    end else if (clr_i) begin
      count_o <= W'(inc_i);
    end else if (inc_i) begin
      count_o <= count_o + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovf_o <= 1'b0;
    end else if (inc_i && !clr_i && (&count_o)) begin
      ovf_o <= 1'b1;
    end else if (clr_i) begin
      ovf_o <= 1'b0;
    end
  end
endmodule // nsa_evt_counter

// ==== hw/nsa_pkg.sv ====
// Purpose: Shared constants for the statistics, serial access and PHY port block
// Assumes: 25 MHz system clock, 32-bit register port
// Notes:   Register offsets are local choices
package nsa_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  STAT_ADDR       = 8'h40;
  localparam logic [7:0]  SER_ADDR        = 8'h48;
  localparam logic [7:0]  PHY_ADDR        = 8'h60;
  // Statistics register layout
  localparam int          STAT_POVF       = 31;
  localparam int          STAT_PCNT_LSB   = 17;
  localparam int          PCNT_W          = 8;
  localparam int          STAT_MOVF       = 16;
  localparam int          MCNT_W          = 7;
  // Serial access register layout
  localparam int          SER_DONE        = 21;
  localparam int          SER_RELOAD      = 20;
  localparam int          SER_MGMT_DATA_SAMPLE        = 19;
  localparam int          SER_MDIR        = 18;
  localparam int          SER_MGMT_DATA_DRIVE       = 17;
  localparam int          SER_MDC         = 16;
  localparam int          SER_RSV12       = 12;
  localparam int          SER_EMODE       = 11;
  localparam int          SER_RSV10       = 10;
  localparam int          SER_RDI         = 3;
  localparam int          SER_RDO         = 2;
  localparam int          SER_RCLK        = 1;
  localparam int          SER_RCS         = 0;
  localparam logic [31:0] SER_FIXED_ONES  = 32'h0000_83f0;
  localparam logic        SER_RSV10_RST   = 1'b1;
  // PHY port register layout
  localparam int          PHY_INIT        = 8;
  localparam int          PHY_RST         = 7;
  localparam int          PHY_STAT_W      = 7;
  // Serial ROM load sequence: start bit, read opcode, word address 0
  localparam int          ROM_CMD_W       = 9;
  localparam logic [8:0]  ROM_CMD         = 9'h180;
  localparam int          ROM_DATA_W      = 16;
  localparam int          CLK_KHZ         = 25000;
  localparam int          ROM_SCLK_KHZ    = 250;
  localparam int          ROM_HALF_CYC    = CLK_KHZ / (2 * ROM_SCLK_KHZ);
  localparam int          PHY_RST_NS      = 1000;
  localparam int          CLK_NS          = 40;
  localparam int          PHY_RST_CYC     = (PHY_RST_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    LD_IDLE,
    LD_CMD,
    LD_DATA,
    LD_DONE
  } nsa_load_e;
endpackage

// ==== hw/nsa_regs.sv ====
// Purpose: Receive statistics, serial bit-bang access and PHY port registers
// Assumes: Event pulses are on clk_i; pins and PHY status are asynchronous
// Notes:   Statistics clear on read; ROM auto-loads after reset
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
module nsa_regs
  import nsa_pkg::*;
#(
  parameter int HALF_CYC = ROM_HALF_CYC,
  parameter int RST_CYC  = PHY_RST_CYC
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // Receive events
  input  wire logic              purge_evt_i,
  input  wire logic              missed_evt_i,
  // Management pins
  output logic                   mdc_o,
  input  wire logic              mdio_i,
  output logic                   mdio_o,
  output logic                   mdio_oe_o,
  // Serial ROM pins
  input  wire logic              rom_serial_in_pin_i,
  output logic                   rom_serial_out_pin_o,
  output logic                   rom_serial_clock_pin_o,
  output logic                   rom_select_pin_o,
  // PHY
  input  wire logic [6:0]        phy_status_i,
  output logic                   phy_reset_o,
  // Loaded ROM word
  output logic [ROM_DATA_W-1:0]  rom_word_o,
  output logic                   eeprom_load_done_o
);
  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);
  localparam logic [15:0] RST_M1  = 16'(RST_CYC - 1);

  logic              wr_stat;
  logic              wr_ser;
  logic              wr_phy;
  logic              rd_stat;
  logic [PCNT_W-1:0] purged_packet_count;
  logic              purged_count_overflow_flag;
  logic [MCNT_W-1:0] missed_frame_count;
  logic              missed_count_overflow_flag;
  logic              mgmt_data_sample;
  logic              rom_in_s;
  logic [6:0]        phy_stat_s;
  // Serial access register state
  logic              eeprom_reload_request_q;
  logic              mgmt_direction_select_q;
  logic              mgmt_data_drive_q;
  logic              mgmt_clock_drive_q;
  logic              rsv12_q;
  logic              rsv10_q;
  logic              eeprom_mode_select_q;
  logic              eeprom_data_to_rom_q;
  logic              eeprom_clock_drive_q;
  logic              eeprom_select_drive_q;
  // PHY port register state
  logic              phy_port_init_control_q;
  logic [7:0]        phy_port_bits_q;
  logic [15:0]       rst_cnt_q;
  // Load engine
  nsa_load_e         ld_state_q;
  logic [15:0]       div_q;
  logic              tick;
  logic              phase_q;
  logic [4:0]        bit_q;
  logic              start_q;
  logic [ROM_CMD_W-1:0] cmd_q;
  logic              load_done_q;
  logic              busy;
  logic [DATA_W-1:0] rd_d;

  assign wr_stat = wr_i && (addr_i == STAT_ADDR);
  assign wr_ser  = wr_i && (addr_i == SER_ADDR);
  assign wr_phy  = wr_i && (addr_i == PHY_ADDR);
  assign rd_stat = rd_i && (addr_i == STAT_ADDR);
  assign busy    = (ld_state_q == LD_CMD) || (ld_state_q == LD_DATA);

  // Counters clear on read so software sees each event once
  nsa_evt_counter #(.W(PCNT_W)) u_purged (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .inc_i    (purge_evt_i),
    .clr_i    (rd_stat),
    .count_o  (purged_packet_count),
    .ovf_o    (purged_count_overflow_flag)
  );

  nsa_evt_counter #(.W(MCNT_W)) u_missed (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .inc_i    (missed_evt_i),
    .clr_i    (rd_stat),
    .count_o  (missed_frame_count),
    .ovf_o    (missed_count_overflow_flag)
  );

  nsa_sync2 #(.W(9)) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      ({mdio_i, rom_serial_in_pin_i, phy_status_i}),
    .q_o      ({mgmt_data_sample, rom_in_s, phy_stat_s})
  );

  // Software fields of the serial access register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mgmt_direction_select_q <= 1'b0;
      mgmt_data_drive_q       <= 1'b0;
      mgmt_clock_drive_q      <= 1'b0;
      rsv12_q                 <= 1'b0;
      rsv10_q                 <= SER_RSV10_RST;
      eeprom_mode_select_q    <= 1'b0;
      eeprom_data_to_rom_q    <= 1'b0;
      eeprom_clock_drive_q    <= 1'b0;
      eeprom_select_drive_q   <= 1'b0;
    end else if (wr_ser) begin
      mgmt_direction_select_q <= wdata_i[SER_MDIR];
      mgmt_data_drive_q       <= wdata_i[SER_MGMT_DATA_DRIVE];
      mgmt_clock_drive_q      <= wdata_i[SER_MDC];
      rsv12_q                 <= wdata_i[SER_RSV12];
      rsv10_q                 <= wdata_i[SER_RSV10];
      eeprom_mode_select_q    <= wdata_i[SER_EMODE];
      eeprom_data_to_rom_q    <= wdata_i[SER_RDO];
      eeprom_clock_drive_q    <= wdata_i[SER_RCLK];
      eeprom_select_drive_q   <= wdata_i[SER_RCS];
    end
  end

  // Reload request stays pending until the engine takes it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eeprom_reload_request_q <= 1'b0;
    end else if (wr_ser && wdata_i[SER_RELOAD]) begin
      eeprom_reload_request_q <= 1'b1;
    end else if (!busy) begin
      // Engine takes it from idle or done; clearing here stops a restart loop
      eeprom_reload_request_q <= 1'b0;
    end
  end

  // Management pins follow the register bits directly
  assign mdc_o     = mgmt_clock_drive_q;
  assign mdio_o    = mgmt_data_drive_q;
  assign mdio_oe_o = mgmt_direction_select_q;

  // Half-period divider for the ROM clock during auto-load
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= '0;
    end else if (!busy || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign tick = busy && (div_q == HALF_M1);

  // Auto-load: one read command, then one data word
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ld_state_q <= LD_IDLE;
      start_q    <= 1'b1;
      phase_q    <= 1'b0;
      bit_q      <= '0;
      cmd_q      <= '0;
      rom_word_o <= '0;
    end else begin
      case (ld_state_q)
        LD_IDLE, LD_DONE: begin
          if (start_q || eeprom_reload_request_q) begin
            ld_state_q <= LD_CMD;
            start_q    <= 1'b0;
            phase_q    <= 1'b0;
            bit_q      <= 5'(ROM_CMD_W - 1);
            cmd_q      <= ROM_CMD;
          end
        end
        LD_CMD: begin
          if (tick) begin
            phase_q <= !phase_q;
            if (phase_q) begin
              cmd_q <= {cmd_q[ROM_CMD_W-2:0], 1'b0};
              if (bit_q == 5'h00) begin
                ld_state_q <= LD_DATA;
                bit_q      <= 5'(ROM_DATA_W - 1);
              end else begin
                bit_q <= bit_q - 5'h01;
              end
            end
          end
        end
        LD_DATA: begin
          if (tick) begin
            phase_q <= !phase_q;
            if (!phase_q) begin
              rom_word_o <= {rom_word_o[ROM_DATA_W-2:0], rom_in_s};
            end else if (bit_q == 5'h00) begin
              ld_state_q <= LD_DONE;
            end else begin
              bit_q <= bit_q - 5'h01;
            end
          end
        end
        default: ld_state_q <= LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      load_done_q <= 1'b0;
    end else if (busy) begin
      load_done_q <= 1'b0;
    end else if (ld_state_q == LD_DONE) begin
      load_done_q <= 1'b1;
    end
  end
  assign eeprom_load_done_o = load_done_q;

  // Engine owns the ROM pins while loading; software only in ROM mode
  always_comb begin
    rom_select_pin_o       = 1'b0;
    rom_serial_clock_pin_o = 1'b0;
    rom_serial_out_pin_o   = 1'b0;
    if (busy) begin
      rom_select_pin_o       = 1'b1;
      rom_serial_clock_pin_o = phase_q;
      rom_serial_out_pin_o   = (ld_state_q == LD_CMD) && cmd_q[ROM_CMD_W-1];
    end else if (eeprom_mode_select_q) begin
      rom_select_pin_o       = eeprom_select_drive_q;
      rom_serial_clock_pin_o = eeprom_clock_drive_q;
      rom_serial_out_pin_o   = eeprom_data_to_rom_q;
    end
  end

  // PHY port register; init code is software's to supply
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phy_port_init_control_q <= 1'b0;
      phy_port_bits_q         <= '0;
    end else if (wr_phy) begin
      phy_port_init_control_q <= wdata_i[PHY_INIT];
      if (wdata_i[PHY_INIT]) begin
        phy_port_bits_q <= wdata_i[7:0];
      end
    end
  end

  // Stretch the reset so the PHY sees a full minimum pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_cnt_q   <= '0;
      phy_reset_o <= 1'b0;
    end else if (wr_phy && !wdata_i[PHY_INIT] && wdata_i[PHY_RST]) begin
      rst_cnt_q   <= RST_M1;
      phy_reset_o <= 1'b1;
    end else if (rst_cnt_q != 16'h0000) begin
      rst_cnt_q <= rst_cnt_q - 16'h0001;
    end else begin
      phy_reset_o <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    rd_d = '0;
    case (addr_i)
      STAT_ADDR: begin
        rd_d[STAT_POVF]                         = purged_count_overflow_flag;
        rd_d[STAT_PCNT_LSB +: PCNT_W]           = purged_packet_count;
        rd_d[STAT_MOVF]                         = missed_count_overflow_flag;
        rd_d[MCNT_W-1:0]                        = missed_frame_count;
      end
      SER_ADDR: begin
        rd_d              = SER_FIXED_ONES;
        rd_d[SER_DONE]    = load_done_q;
        rd_d[SER_RELOAD]  = eeprom_reload_request_q;
        rd_d[SER_MGMT_DATA_SAMPLE]    = mgmt_data_sample;
        rd_d[SER_MDIR]    = mgmt_direction_select_q;
        rd_d[SER_MGMT_DATA_DRIVE]   = mgmt_data_drive_q;
        rd_d[SER_MDC]     = mgmt_clock_drive_q;
        rd_d[SER_RSV12]   = rsv12_q;
        rd_d[SER_EMODE]   = eeprom_mode_select_q;
        rd_d[SER_RSV10]   = rsv10_q;
        rd_d[SER_RDI]     = eeprom_mode_select_q && rom_in_s;
        rd_d[SER_RDO]     = eeprom_data_to_rom_q;
        rd_d[SER_RCLK]    = eeprom_clock_drive_q;
        rd_d[SER_RCS]     = eeprom_select_drive_q;
      end
      PHY_ADDR: begin
        rd_d[PHY_INIT] = phy_port_init_control_q;
        if (phy_port_init_control_q) begin
          rd_d[7:0] = phy_port_bits_q;
        end else begin
          rd_d[PHY_STAT_W-1:0] = phy_stat_s;
        end
      end
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rd_i ? rd_d : '0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_stat_rd;
    rd_i && addr_i == STAT_ADDR;
  endsequence

  a_purge_ovf_set: assert property (
    purge_evt_i && !rd_stat && (&purged_packet_count) |=> purged_count_overflow_flag
  ) else $error("purged overflow flag not set");

  a_purge_cnt_inc: assert property (
    purge_evt_i && !rd_stat |=> purged_packet_count == $past(purged_packet_count) + 8'h01
  ) else $error("purged count did not advance");

  a_missed_ovf_set: assert property (
    missed_evt_i && !rd_stat && (&missed_frame_count) |=> missed_count_overflow_flag
  ) else $error("missed overflow flag not set");

  a_missed_rd_clr: assert property (
    s_stat_rd ##0 !missed_evt_i |=> missed_frame_count == 7'h00
      && rdata_o[MCNT_W-1:0] == $past(missed_frame_count)
  ) else $error("missed count not reported or cleared");

  a_load_done_flag: assert property (
    ld_state_q == LD_DATA ##1 ld_state_q == LD_DONE |=> eeprom_load_done_o
  ) else $error("load done not set");

  a_reload_starts: assert property (
    wr_ser && wdata_i[SER_RELOAD] && !busy |-> ##[1:2] ld_state_q == LD_CMD
  ) else $error("reload did not start");

  a_mgmt_data_sample_readback: assert property (
    rd_i && addr_i == SER_ADDR |=> rdata_o[SER_MGMT_DATA_SAMPLE] == $past(mgmt_data_sample)
  ) else $error("management data sample misreported");

  a_mdio_direction: assert property (
    wr_ser |=> mdio_oe_o == $past(wdata_i[SER_MDIR]) && mdio_o == $past(wdata_i[SER_MGMT_DATA_DRIVE])
  ) else $error("management data pin not as written");

  a_mdc_follows: assert property (
    wr_ser ##1 !wr_ser |=> mdc_o == $past(wdata_i[SER_MDC], 2) && $stable(mdc_o)
  ) else $error("management clock not as written");

  a_ser_reserved: assert property (
    rd_i && addr_i == SER_ADDR |=> (rdata_o & SER_FIXED_ONES) == SER_FIXED_ONES
  ) else $error("reserved serial bits not one");

  a_rom_idle_quiet: assert property (
    !eeprom_mode_select_q && !busy |-> !rom_select_pin_o && !rom_serial_clock_pin_o
  ) else $error("rom pins active outside rom mode");

  a_rom_mode_cs: assert property (
    eeprom_mode_select_q && !busy |-> rom_select_pin_o == eeprom_select_drive_q
  ) else $error("rom select not driven from bit 0");

  a_phy_reset_pulse: assert property (
    wr_phy && !wdata_i[PHY_INIT] && wdata_i[PHY_RST] |=> phy_reset_o && rst_cnt_q == RST_M1
  ) else $error("phy reset pulse not started");

  // Pulse length is carried by the counter, not a long repetition
  a_phy_reset_hold: assert property (
    rst_cnt_q != 16'h0000 |=> phy_reset_o
  ) else $error("phy reset pulse too short");

  a_phy_reset_end: assert property (
    rst_cnt_q == 16'h0000 && !wr_phy |=> !phy_reset_o
  ) else $error("phy reset pulse too long");

  a_phy_wr_ignored: assert property (
    wr_phy && !wdata_i[PHY_INIT] |=> $stable(phy_port_bits_q)
  ) else $error("phy status bits took a write");
endmodule // nsa_regs

// ==== hw/nsa_sync2.sv ====
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are quasi-static levels
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module nsa_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // nsa_sync2

// ==== tb/nsa_regs_test.sv ====
// Purpose: Self-checking bench for nsa_regs
// Assumes: Short ROM half bit and PHY reset stretch
// Notes:   ROM and management wire come from nsa_rom_model
`timescale 1ns/10ps
module nsa_regs_test
  import nsa_pkg::*;
;
  localparam int HC = 2;
  localparam int RC = 3;
  logic              clk_i, arst_n_i, wr_i, rd_i, purge_evt_i, missed_evt_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata, got, exp_v;
  logic              mdc, mdw, mdo, mdoe, rin, rout, sclk, sel, prst, done, lvl;
  logic [6:0]        phy_status_i;
  logic [15:0]       rword, word;
  int                fails, tests_run, n;
  logic [31:0] row_w [5] = '{32'h0007_0000, 32'h0002_0000, 32'h0000_0007,
                             32'h0000_1c05, 32'h0000_0c02};
  logic        row_l [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [5:0]  row_p [5] = '{6'h38, 6'h10, 6'h00, 6'h05, 6'h02};

  nsa_regs #(.HALF_CYC(HC), .RST_CYC(RC)) i_nsa_regs (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .purge_evt_i(purge_evt_i),
    .missed_evt_i(missed_evt_i), .mdc_o(mdc), .mdio_i(mdw), .mdio_o(mdo),
    .mdio_oe_o(mdoe), .rom_serial_in_pin_i(rin), .rom_serial_out_pin_o(rout),
    .rom_serial_clock_pin_o(sclk), .rom_select_pin_o(sel),
    .phy_status_i(phy_status_i), .phy_reset_o(prst), .rom_word_o(rword),
    .eeprom_load_done_o(done));

  nsa_rom_model i_nsa_rom_model (
    .sel_i(sel), .sclk_i(sclk), .sdi_i(rout), .sdo_o(rin), .word_i(word),
    .md_i(mdo), .md_oe_i(mdoe), .lvl_i(lvl), .md_o(mdw));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic end_sim();
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata, e);
  endtask

  task automatic ev(input int np, input int nm);
    for (int i = 0; i < np || i < nm; i++) begin
      @(posedge clk_i);
      purge_evt_i  <= (i < np);
      missed_evt_i <= (i < nm);
      @(posedge clk_i);
      purge_evt_i  <= 1'b0;
      missed_evt_i <= 1'b0;
    end
  endtask

  task automatic wdone();
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n >= 500) begin
      fails++;
      $display("CHECK FAILED %0t load never finished", $time);
      end_sim();
    end
  endtask

  initial begin
    arst_n_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    purge_evt_i = 1'b0;
    missed_evt_i = 1'b0;
    phy_status_i = 7'h55;
    lvl = 1'b0;
    word = 16'ha5c3;
    fails = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_i);
    chk({done, prst, sel, sclk, mdoe}, 32'h0);
    arst_n_i <= 1'b1;
    wdone();
    chk(rword, 16'ha5c3);
    rchk(SER_ADDR, SER_FIXED_ONES | 32'h0020_0400);
    for (int i = 0; i < 5; i++) begin
      lvl <= row_l[i];
      wr(SER_ADDR, row_w[i]);
      repeat (4) @(posedge clk_i);
      exp_v = SER_FIXED_ONES | 32'h0020_0000 | (row_w[i] & 32'h0007_1c07);
      exp_v[SER_MGMT_DATA_SAMPLE] = row_w[i][SER_MDIR] ? row_w[i][SER_MGMT_DATA_DRIVE] : row_l[i];
      exp_v[SER_RDI] = row_w[i][SER_EMODE] & rin;
      rchk(SER_ADDR, exp_v);
      chk({mdc, mdo, mdoe, rout, sclk, sel}, row_p[i]);
    end
    // A fresh word proves the reload really reads the ROM again
    word <= 16'h3c96;
    wr(SER_ADDR, 32'h0010_0000);
    repeat (2) @(posedge clk_i);
    #1 chk(done, 32'h0);
    wdone();
    chk(rword, 16'h3c96);
    ev(3, 4);
    rchk(STAT_ADDR, 32'h0006_0004);
    ev(261, 130);
    rchk(STAT_ADDR, 32'h800b_0002);
    rchk(STAT_ADDR, 32'h0000_0000);
    wr(PHY_ADDR, 32'h0000_0180);
    rchk(PHY_ADDR, 32'h0000_0180);
    phy_status_i <= 7'h2a;
    wr(PHY_ADDR, 32'h0000_007f);
    rchk(PHY_ADDR, 32'h0000_002a);
    chk(prst, 32'h0);
    wr(PHY_ADDR, 32'h0000_0080);
    n = 0;
    repeat (RC + 3) begin
      #1 n += (prst === 1'b1);
      @(posedge clk_i);
    end
    chk(n, RC);
    wr(8'h44, 32'hffff_ffff);
    rchk(8'h44, 32'h0000_0000);
    arst_n_i <= 1'b0;
    @(posedge clk_i);
    #1 chk({done, prst, sel}, 32'h0);
    arst_n_i <= 1'b1;
    wdone();
    chk(rword, 16'h3c96);
    end_sim();
  end
endmodule // nsa_regs_test

// ==== tb/nsa_rom_model.sv ====
// Purpose: Serial ROM and management wire partner for nsa_regs
// Assumes: ROM answers a read of word 0, MSB first after the command
// Notes:   Deselected ROM data shows the inverse of its last value
`timescale 1ns/10ps
module nsa_rom_model (
  // ROM pins
  input  wire logic        sel_i,
  input  wire logic        sclk_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  input  wire logic [15:0] word_i,
  // Management wire
  input  wire logic        md_i,
  input  wire logic        md_oe_i,
  input  wire logic        lvl_i,
  output logic             md_o
);
  logic [8:0] cmd_q;
  int         cnt_q = 0;
  initial sdo_o = 1'b0;
  // PHY drives only while the device has let go
  assign md_o = md_oe_i ? md_i : lvl_i;
  always @(posedge sclk_i or negedge sel_i) begin
    if (!sel_i) begin
      cnt_q = 0;
      sdo_o = ~sdo_o;
    end else begin
      if (cnt_q < 9) cmd_q = {cmd_q[7:0], sdi_i};
      cnt_q = cnt_q + 1;
      if (cnt_q >= 9 && cnt_q < 25 && cmd_q == 9'h180) sdo_o = word_i[24-cnt_q];
    end
  end
endmodule // nsa_rom_model
